// [hw/sbc_defines.svh]
// Offsets, field positions, reset values and timing counts of the serial bus control block
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

`define SBC_ADDR_W          8
`define SBC_ADDR_CTRL_ONE   8'h00
`define SBC_ADDR_CTRL_TWO   8'h04
`define SBC_ADDR_DATA       8'h08
`define SBC_ADDR_IRQ_STAT   8'h0C
`define SBC_ADDR_IRQ_MASK   8'h10

// Control one fields
`define SBC_C1_BC_HI        7
`define SBC_C1_BC_LO        5
`define SBC_C1_ACK          4
`define SBC_C1_ONE          3
`define SBC_C1_SCK_HI       2
`define SBC_C1_SCK_LO       0
`define SBC_C1_BC_RST       3'h0
`define SBC_C1_ACK_RST      1'h0
`define SBC_C1_SCK_RST      3'h0

// Control two fields
`define SBC_C2_MST          7
`define SBC_C2_TRX          6
`define SBC_C2_BB           5
`define SBC_C2_PIN          4
`define SBC_C2_MODE_HI      3
`define SBC_C2_MODE_LO      2
`define SBC_C2_SWR_HI       1
`define SBC_C2_SWR_LO       0
`define SBC_C2_RST          8'h10

// Mode and reset codes
`define SBC_MODE_PORT       2'h0
`define SBC_MODE_SIO        2'h1
`define SBC_MODE_I2C        2'h2
`define SBC_SWR_FIRST       2'h2
`define SBC_SWR_SECOND      2'h1

// Interrupt status bits
`define SBC_IRQ_N           2
`define SBC_IRQ_DONE        0
`define SBC_IRQ_SRST        1

// Timing
`define SBC_CLK_NS          8
`define SBC_SOFT_RST_NS     40
`define SBC_SOFT_RST_CYC    ((`SBC_SOFT_RST_NS + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
`define SBC_QUARTER_BASE    16

`endif

// [hw/sbc_pkg.sv]
// Types shared by the serial bus control block
`default_nettype none
package sbc_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RSTART,
    ST_START_A,
    ST_START_B,
    ST_LOW,
    ST_HIGH,
    ST_STOP_A,
    ST_STOP_B,
    ST_STOP_C
  } sbc_state_t;

  typedef struct packed {
    logic [2:0] bit_count_select;
    logic       ack_en;
    logic [2:0] sck;
  } sbc_ctrl_one_t;

  typedef struct packed {
    logic       master_select;
    logic       transmit_select;
    logic [1:0] interface_mode_select;
  } sbc_ctrl_two_t;

endpackage
`default_nettype wire

// [hw/sbc_sync3.sv]
// Three-stage input synchroniser with agreement filter
`default_nettype none
module sbc_sync3 #(
  parameter int W = 2
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  wire  [W-1:0] agree = ~(stage2 ^ stage3);
  wire  [W-1:0] next_sync = (agree & stage3) | (~agree & sync_o);

  // Idle bus level is high, so reset to ones
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stage1 <= {W{1'b1}};
      stage2 <= {W{1'b1}};
      stage3 <= {W{1'b1}};
      sync_o <= {W{1'b1}};
    end
    else
    begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_o <= next_sync;
    end
  end
endmodule // sbc_sync3
`default_nettype wire

// [hw/sbc_irq.sv]
// Sticky interrupt status, mask and level output
`default_nettype none
module sbc_irq #(
  parameter int N = 2
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [N-1:0] event_i,
  input  wire logic         clr_wr_i,
  input  wire logic         mask_wr_i,
  input  wire logic [N-1:0] wdata_i,
  output logic      [N-1:0] status_o,
  output logic      [N-1:0] mask_o,
  output logic              irq_o
);
  // Set beats a same-cycle write-one clear
  wire [N-1:0] clr_bits    = clr_wr_i ? wdata_i : {N{1'b0}};
  wire [N-1:0] next_status = (status_o & ~clr_bits) | event_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      status_o <= {N{1'b0}};
      mask_o   <= {N{1'b0}};
      irq_o    <= 1'b0;
    end
    else
    begin
      status_o <= next_status;
      if (mask_wr_i)
      begin
        mask_o <= wdata_i;
      end
      irq_o <= |(next_status & (mask_wr_i ? wdata_i : mask_o));
    end
  end
endmodule // sbc_irq
`default_nettype wire

// [hw/sbc_top.sv]
// Serial bus control fields with transfer engine and register port
//
// Contract
// [R1] Reset monitor bit reads 0 during software reset, 1 otherwise.
// [R2] Bit count 000 means 8 bits; clocks are length plus optional ack.
// [R3] Software clears bit count before entering SIO mode.
// [R4] Shared bit 0 reads 1 after reset; 0 as clock select in SIO.
// [R5] Clock frequency selection starts at code 000 after reset.
// [R6] Multi-master software uses bit count of two or more before stop.
// [R7] Writing 1 clears pending transfer interrupt; 0 does nothing; resets 1 (pending here resets to 0).
// [R8] Software reset happens only after code 10 then code 01.
// [R9] Mode field: 00 port, 01 SIO, 10 I2C, 11 reserved.
// [R10] Start/stop bit written 1 makes start, written 0 makes stop.
// [R11] Software ensures bus free and lines high when changing modes.
// [R12] Master bit 1 master, 0 slave; transmit bit 1 tx; both reset 0.
//
// The address map and strobed register access were left to the implementer.
`include "sbc_defines.svh"
`default_nettype none
module sbc_top #(
  parameter int QUARTER_BASE = `SBC_QUARTER_BASE
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_n_i,
  input  wire logic [`SBC_ADDR_W-1:0] addr_i,
  input  wire logic [31:0]            wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [31:0]            rdata_o,
  output logic                        irq_o,
  output logic                        transfer_interrupt_o,
  input  wire logic                   scl_i,
  output logic                        scl_o,
  output logic                        scl_oe_o,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe_o
);
  localparam logic [3:0] SRST_CYC = 4'(`SBC_SOFT_RST_CYC);

  function automatic logic [3:0] sbc_data_len(input logic [2:0] bc);
    sbc_data_len = (bc == 3'h0) ? 4'h8 : {1'b0, bc};
  endfunction

  sbc_pkg::sbc_ctrl_one_t ctrl_one;
  sbc_pkg::sbc_ctrl_two_t ctrl_two;
  sbc_pkg::sbc_state_t    state;
  sbc_pkg::sbc_state_t    next_state;
  logic [7:0]  shreg;
  logic [3:0]  bits_left;
  logic        ack_bit;
  logic        bus_owned;
  logic        pending;
  logic        swr_armed;
  logic [3:0]  srst_cnt;
  logic [15:0] qcnt;
  logic        start_req;
  logic        stop_req;
  logic        go_req;
  logic [1:0]  lines_s;
  logic [`SBC_IRQ_N-1:0] irq_stat;
  logic [`SBC_IRQ_N-1:0] irq_mask;

  sbc_sync3 #(.W(2)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({scl_i, sda_i}),
    .sync_o    (lines_s)
  );
  wire scl_s = lines_s[1];
  wire sda_s = lines_s[0];

  // Register decode
  wire wr_one  = wr_i && (addr_i == `SBC_ADDR_CTRL_ONE);
  wire wr_two  = wr_i && (addr_i == `SBC_ADDR_CTRL_TWO);
  wire wr_data = wr_i && (addr_i == `SBC_ADDR_DATA);
  wire wr_stat = wr_i && (addr_i == `SBC_ADDR_IRQ_STAT);
  wire wr_mask = wr_i && (addr_i == `SBC_ADDR_IRQ_MASK);
  wire [1:0] swr_code = wdata_i[`SBC_C2_SWR_HI:`SBC_C2_SWR_LO];
  wire [1:0] mode     = ctrl_two.interface_mode_select;
  wire mode_i2c = (mode == `SBC_MODE_I2C);                              // [R9]
  wire mode_sio = (mode == `SBC_MODE_SIO);                              // [R9]
  wire mode_out = mode_i2c || mode_sio;   // Port and reserved drive nothing [R9]
  wire i2c_mst  = mode_i2c && ctrl_two.master_select;                  // [R12]
  wire srst_fire = wr_two && swr_armed && (swr_code == `SBC_SWR_SECOND); // [R8]
  wire srst_busy = (srst_cnt != 4'h0);
  wire srst_done = (srst_cnt == 4'h1);
  wire reset_monitor = !srst_busy;                                      // [R1]

  // Half-bit timebase (one SCL low or high phase), scaled by the clock select field
  wire [15:0] q_period = 16'(QUARTER_BASE) << ctrl_one.sck;
  wire        tick     = (qcnt >= q_period - 16'h1);
  wire        is_ack   = ctrl_one.ack_en && (bits_left == 4'h1);
  wire        done     = (state == sbc_pkg::ST_HIGH) && tick && scl_s && (bits_left == 4'h1);
  wire [3:0]  total    = sbc_data_len(ctrl_one.bit_count_select)
                       + {3'h0, ctrl_one.ack_en};                        // [R2]

  // Line drive: open drain, enable means pull low
  logic drive_scl;
  logic drive_sda;
  always_comb
  begin
    drive_scl = 1'b0;
    drive_sda = 1'b0;
    case (state)
      sbc_pkg::ST_IDLE:    drive_scl = bus_owned;
      sbc_pkg::ST_RSTART:  drive_scl = 1'b0;
      sbc_pkg::ST_START_A: drive_sda = 1'b1;                            // [R10]
      sbc_pkg::ST_START_B:
      begin
        drive_sda = 1'b1;
        drive_scl = 1'b1;
      end
      sbc_pkg::ST_LOW:
      begin
        drive_scl = 1'b1;
        drive_sda = is_ack ? !ctrl_two.transmit_select
                           : (ctrl_two.transmit_select && !shreg[7]);   // [R12]
      end
      sbc_pkg::ST_HIGH:
      begin
        drive_sda = is_ack ? !ctrl_two.transmit_select
                           : (ctrl_two.transmit_select && !shreg[7]);
      end
      sbc_pkg::ST_STOP_A:
      begin
        drive_scl = 1'b1;
        drive_sda = 1'b1;
      end
      sbc_pkg::ST_STOP_B:  drive_sda = 1'b1;                            // [R10]
      sbc_pkg::ST_STOP_C:  drive_sda = 1'b0;
      default:
      begin
        drive_scl = 1'b0;
        drive_sda = 1'b0;
      end
    endcase
  end

  // Engine sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      sbc_pkg::ST_IDLE:
      begin
        if (start_req && i2c_mst)
        begin
          next_state = bus_owned ? sbc_pkg::ST_RSTART : sbc_pkg::ST_START_A;  // [R10]
        end
        else if (stop_req && i2c_mst && bus_owned)
        begin
          next_state = sbc_pkg::ST_STOP_A;                              // [R10]
        end
        else if (go_req && (mode_sio || (i2c_mst && bus_owned)))
        begin
          next_state = sbc_pkg::ST_LOW;
        end
      end
      sbc_pkg::ST_RSTART:  next_state = (tick && scl_s) ? sbc_pkg::ST_START_A : state;
      sbc_pkg::ST_START_A: next_state = tick ? sbc_pkg::ST_START_B : state;
      sbc_pkg::ST_START_B: next_state = tick ? sbc_pkg::ST_IDLE : state;
      sbc_pkg::ST_LOW:     next_state = tick ? sbc_pkg::ST_HIGH : state;
      // Waiting for SCL high honours a stretching slave
      sbc_pkg::ST_HIGH:
      begin
        if (tick && scl_s)
        begin
          next_state = (bits_left == 4'h1) ? sbc_pkg::ST_IDLE : sbc_pkg::ST_LOW;
        end
      end
      sbc_pkg::ST_STOP_A:  next_state = tick ? sbc_pkg::ST_STOP_B : state;
      sbc_pkg::ST_STOP_B:  next_state = (tick && scl_s) ? sbc_pkg::ST_STOP_C : state;
      sbc_pkg::ST_STOP_C:  next_state = tick ? sbc_pkg::ST_IDLE : state;
      default:             next_state = sbc_pkg::ST_IDLE;
    endcase
    if (!mode_out)
    begin
      next_state = sbc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state     <= sbc_pkg::ST_IDLE;
      qcnt      <= 16'h0;
      bits_left <= 4'h0;
      shreg     <= 8'h00;
      ack_bit   <= 1'b1;
      bus_owned <= 1'b0;
    end
    else if (srst_busy)
    begin
      state     <= sbc_pkg::ST_IDLE;
      qcnt      <= 16'h0;
      bits_left <= 4'h0;
      shreg     <= 8'h00;
      ack_bit   <= 1'b1;
      bus_owned <= 1'b0;
    end
    else
    begin
      state <= next_state;
      qcnt  <= (state == sbc_pkg::ST_IDLE || tick) ? 16'h0 : qcnt + 16'h1;
      if (wr_data && state == sbc_pkg::ST_IDLE)
      begin
        shreg <= wdata_i[7:0];
      end
      if (state == sbc_pkg::ST_IDLE && next_state == sbc_pkg::ST_LOW)
      begin
        bits_left <= total;                                             // [R2]
      end
      if (state == sbc_pkg::ST_HIGH && tick && scl_s)
      begin
        bits_left <= bits_left - 4'h1;
        if (is_ack)
        begin
          ack_bit <= sda_s;
        end
        else
        begin
          shreg <= {shreg[6:0], sda_s};
        end
      end
      if (state == sbc_pkg::ST_START_B && tick)
      begin
        bus_owned <= 1'b1;
      end
      if ((state == sbc_pkg::ST_STOP_C && tick) || !mode_i2c)
      begin
        bus_owned <= 1'b0;
      end
    end
  end

  // Control registers and software reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_one  <= '{`SBC_C1_BC_RST, `SBC_C1_ACK_RST, `SBC_C1_SCK_RST}; // [R5]
      ctrl_two  <= '{1'b0, 1'b0, `SBC_MODE_PORT};                       // [R12]
      start_req <= 1'b0;
      stop_req  <= 1'b0;
      go_req    <= 1'b0;
      pending   <= 1'b0;
      swr_armed <= 1'b0;
      srst_cnt  <= 4'h0;
    end
    else
    begin
      start_req <= wr_two && wdata_i[`SBC_C2_BB];                       // [R10]
      stop_req  <= wr_two && !wdata_i[`SBC_C2_BB] && bus_owned;         // [R10]
      go_req    <= wr_data;
      if (wr_one)
      begin
        ctrl_one <= '{wdata_i[`SBC_C1_BC_HI:`SBC_C1_BC_LO], wdata_i[`SBC_C1_ACK],
                      wdata_i[`SBC_C1_SCK_HI:`SBC_C1_SCK_LO]};
      end
      if (wr_two)
      begin
        ctrl_two <= '{wdata_i[`SBC_C2_MST], wdata_i[`SBC_C2_TRX],
                      wdata_i[`SBC_C2_MODE_HI:`SBC_C2_MODE_LO]};        // [R9]
        swr_armed <= (swr_code == `SBC_SWR_FIRST);                      // [R8]
      end
      // Pending set wins over a same-cycle clear
      if (done)
      begin
        pending <= 1'b1;
      end
      else if (wr_two && wdata_i[`SBC_C2_PIN])
      begin
        pending <= 1'b0;                                                // [R7]
      end
      if (srst_fire)
      begin
        srst_cnt <= SRST_CYC;                                           // [R8]
      end
      else if (srst_busy)
      begin
        srst_cnt <= srst_cnt - 4'h1;
        ctrl_two <= '{1'b0, 1'b0, `SBC_MODE_PORT};
        pending  <= 1'b0;
      end
    end
  end

  sbc_irq #(.N(`SBC_IRQ_N)) u_irq (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .event_i   ({srst_done, done}),
    .clr_wr_i  (wr_stat),
    .mask_wr_i (wr_mask),
    .wdata_i   (wdata_i[`SBC_IRQ_N-1:0]),
    .status_o  (irq_stat),
    .mask_o    (irq_mask),
    .irq_o     (irq_o)
  );

  // Bit 0 shows the monitor, except in SIO where it is the clock select
  wire bit0 = mode_sio ? ctrl_one.sck[0] : reset_monitor;               // [R4] [R1]
  wire [31:0] rd_one  = {24'h0, ctrl_one.bit_count_select, ctrl_one.ack_en,
                         1'b1, ctrl_one.sck[2:1], bit0};
  wire [31:0] rd_two  = {24'h0, ctrl_two.master_select, ctrl_two.transmit_select,
                         bus_owned, pending, mode, ack_bit, (state != sbc_pkg::ST_IDLE)};
  wire [31:0] rd_mux  = (addr_i == `SBC_ADDR_CTRL_ONE) ? rd_one :
                        (addr_i == `SBC_ADDR_CTRL_TWO) ? rd_two :
                        (addr_i == `SBC_ADDR_DATA)     ? {24'h0, shreg} :
                        (addr_i == `SBC_ADDR_IRQ_STAT) ? {30'h0, irq_stat} :
                        (addr_i == `SBC_ADDR_IRQ_MASK) ? {30'h0, irq_mask} : 32'h0;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o              <= 32'h0;
      transfer_interrupt_o <= 1'b0;
      scl_o                <= 1'b0;
      sda_o                <= 1'b0;
      scl_oe_o             <= 1'b0;
      sda_oe_o             <= 1'b0;
    end
    else
    begin
      rdata_o              <= rd_i ? rd_mux : 32'h0;
      transfer_interrupt_o <= pending;                                  // [R7]
      scl_o                <= 1'b0;
      sda_o                <= 1'b0;
      scl_oe_o             <= drive_scl && mode_out;                    // [R9]
      sda_oe_o             <= drive_sda && mode_out;                    // [R9]
    end
  end
endmodule // sbc_top
`default_nettype wire

// [bench/sbc_top_chk.sv]
// Concurrent checks on the serial bus control ports
`include "sbc_defines.svh"
`default_nettype none
module sbc_top_chk #(
  parameter int QUARTER_BASE = 16
) (
  input wire logic                   clk_sys_i,
  input wire logic                   rst_n_i,
  input wire logic [`SBC_ADDR_W-1:0] addr_i,
  input wire logic [31:0]            wdata_i,
  input wire logic                   wr_i,
  input wire logic                   rd_i,
  input wire logic [31:0]            rdata_o,
  input wire logic                   irq_o,
  input wire logic                   transfer_interrupt_o,
  input wire logic                   scl_oe_o,
  input wire logic                   sda_oe_o,
  input wire logic                   scl_o,
  input wire logic                   sda_o
);
  logic       armed;
  logic [1:0] mode;
  logic [3:0] since;
  wire        c2_wr = wr_i && addr_i == 8'h04;
  wire        fire  = c2_wr && armed && wdata_i[1:0] == 2'h1;

  // Shadow of mode and reset arming, as the ports reveal them
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      armed <= 1'b0;
      mode  <= 2'h0;
      since <= 4'hF;
    end
    else if (c2_wr)
    begin
      armed <= wdata_i[1:0] == 2'h2;
      mode  <= fire ? 2'h0 : wdata_i[3:2];
      since <= 4'h0;
    end
    else if (since != 4'hF)
      since <= since + 4'h1;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_c1_read;
    rd_i && addr_i == 8'h00;
  endsequence
  sequence s_fire_read;
    fire ##[1:3] s_c1_read;
  endsequence

  a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read cycle");
  a_c1_fixed: assert property (s_c1_read |=> rdata_o[3] && rdata_o[31:8] == 24'h0)
    else $error("fixed bits of control one wrong");
  a_srst_monitor: assert property (s_fire_read |=> !rdata_o[0])
    else $error("monitor not low during soft reset");
  a_srst_roles: assert property (fire ##[1:6] (rd_i && addr_i == 8'h04)
    |=> rdata_o[7:6] == 2'h0)
    else $error("roles not cleared by soft reset");
  a_port_quiet: assert property ((mode == 2'h0 || mode == 2'h3) && since == 4'hF
    |-> !scl_oe_o && !sda_oe_o)
    else $error("pins driven in port mode");
  a_ti_held: assert property (transfer_interrupt_o && !c2_wr && !$past(c2_wr)
    |=> transfer_interrupt_o)
    else $error("transfer interrupt dropped without clear");
  a_done_holds: assert property ($rose(transfer_interrupt_o) |-> scl_oe_o)
    else $error("clock line not held after transfer");
  a_irq_masked: assert property ((wr_i && addr_i == 8'h10 && wdata_i[1:0] == 2'h0)
    ##1 !(wr_i && addr_i == 8'h10) |=> !irq_o)
    else $error("interrupt high while masked");
  a_unmapped_zero: assert property (rd_i && addr_i > 8'h10 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_open_drain_low: assert property (!scl_o && !sda_o)
    else $error("open drain output value not low");
endmodule // sbc_top_chk

bind sbc_top sbc_top_chk #(.QUARTER_BASE(QUARTER_BASE)) sbc_top_chk_inst (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .transfer_interrupt_o(transfer_interrupt_o), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
  .scl_o(scl_o), .sda_o(sda_o));
`default_nettype wire

// [bench/sbc_peer.sv]
// Bus partner: pull-ups, slave acknowledge, capture and clock stretching
`default_nettype none
module sbc_peer (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       scl_oe_i,
  input  wire logic       sda_oe_i,
  input  wire logic [3:0] len_i,
  input  wire logic       ack_i,
  input  wire logic [3:0] stretch_i,
  output logic            scl_o,
  output logic            sda_o,
  output logic [3:0]      rises_o,
  output logic [7:0]      rx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       scl_q;
  logic       sda_q;
  logic       ack_low;
  logic [3:0] hold;
  wire        rise = scl_o && !scl_q;
  wire        fall = !scl_o && scl_q;

  // Released lines float high through the pull-ups
  assign scl_o = !(scl_oe_i || hold != 4'h0);
  assign sda_o = !(sda_oe_i || ack_low);

  always @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      hold    <= 4'h0;
      ack_low <= 1'b0;
      rises_o <= 4'h0;
      rx_o    <= 8'h0;
    end
    else
    begin
      scl_q <= scl_o;
      sda_q <= sda_o;
      if (scl_o && sda_q && !sda_o)
      begin
        rises_o <= 4'h0;
        rx_o    <= 8'h0;
      end
      else if (rise)
      begin
        rises_o <= rises_o + 4'h1;
        if (rises_o < len_i)
          rx_o <= {rx_o[6:0], sda_o};
      end
      // Slow partner holds the clock low after each fall
      if (fall)
        hold <= stretch_i;
      else if (hold != 4'h0)
        hold <= hold - 4'h1;
      if (fall)
        ack_low <= ack_i && rises_o == len_i;
    end
endmodule // sbc_peer
`default_nettype wire

// [bench/serial_bus_control_fields_bench.sv]
// Self-checking bench for the serial bus control block
`default_nettype none
module serial_bus_control_fields_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic [7:0]  addr_i    = 8'h00;
  logic [31:0] wdata_i   = 32'h0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [31:0] rdata_o;
  logic        irq_o, ti, scl_oe, sda_oe, scl_w, sda_w, ack = 1'b0;
  logic [3:0]  len = 4'h8, stretch = 4'h0, rises;
  logic [7:0]  rx;
  logic [31:0] d;
  logic [3:0]  tab [3] = '{4'h1, 4'h6, 4'hF};
  int          bad_count = 0, n_compared = 0, cyc = 0;

  // Quarter of 10 cycles hides the sync delay: 160 ns link clock when nobody stretches
  sbc_top #(.QUARTER_BASE(10)) sbc_top_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .transfer_interrupt_o(ti),
    .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe));
  sbc_peer sbc_peer_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
    .len_i(len), .ack_i(ack), .stretch_i(stretch), .scl_o(scl_w), .sda_o(sda_w),
    .rises_o(rises), .rx_o(rx));

  initial
  begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic end_of_test;
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      end_of_test;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    d = rdata_o;
    if (name != "")
      chk(name, exp, d);
  endtask

  // Poll status view of control two until the masked bits match
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 400; i++)
    begin
      rchk("", 8'h04, 32'h0);
      if ((d & m) === v)
        return;
    end
    chk("ctrl_two poll", v, d & m);
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rchk("ctrl_one reset", 8'h00, 32'h9);
    rchk("ctrl_two reset", 8'h04, 32'h2);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h04, 32'(m << 2));
      rchk("mode monitor", 8'h00, (m == 1) ? 32'h8 : 32'h9);
    end
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h50);
    wr(8'h04, 32'h2);
    wr(8'h04, 32'h0);
    wr(8'h04, 32'h1);
    rchk("no reset", 8'h00, 32'h59);
    wr(8'h04, 32'h2);
    wr(8'h04, 32'h1);
    rchk("reset busy", 8'h00, 32'h58);
    rchk("", 8'h04, 32'h0);
    chk("roles", 32'h0, d & 32'hC0);
    repeat (8) @(posedge clk_sys_i);
    rchk("reset over", 8'h00, 32'h59);
    rchk("status", 8'h0C, 32'h2);
    wr(8'h0C, 32'h2);
    rchk("status clr", 8'h0C, 32'h0);
    wr(8'h14, 32'hFF);
    rchk("unmapped", 8'h14, 32'h0);
    wr(8'h10, 32'h1);
    for (int t = 0; t < 3; t++)
    begin
      len     <= (tab[t][3:1] == 3'h0) ? 4'h8 : {1'b0, tab[t][3:1]};
      ack     <= tab[t][0];
      stretch <= 4'(t * 6);
      wr(8'h00, {24'h0, tab[t], 4'h0});
      wr(8'h04, 32'hF8);
      poll(32'h21, 32'h20);
      wr(8'h08, 32'hA5);
      poll(32'h11, 32'h10);
      chk("pending", 32'h1, {31'h0, ti});
      chk("irq", 32'h1, {31'h0, irq_o});
      chk("clocks", 32'(len + ack), {28'h0, rises});
      chk("data", 32'(8'hA5 >> (8 - len)), {24'h0, rx});
      if (ack)
        chk("ack", 32'h0, d & 32'h2);
      wr(8'h0C, 32'h1);
      @(negedge clk_sys_i);
      chk("irq clr", 32'h0, {31'h0, irq_o});
    end
    // Receive: peer stays silent, so data reads ones and the ack is ours
    ack <= 1'b0;
    wr(8'h04, 32'hB8);
    poll(32'h21, 32'h20);
    wr(8'h08, 32'h0);
    poll(32'h11, 32'h10);
    chk("master ack", 32'h0, d & 32'h2);
    rchk("rx data", 8'h08, 32'h7F);
    wr(8'h04, 32'hC8);
    poll(32'h21, 32'h00);
    chk("pending kept", 32'h1, {31'h0, ti});
    chk("sda free", 32'h1, {31'h0, sda_w});
    wr(8'h04, 32'hD8);
    repeat (2) @(negedge clk_sys_i);
    chk("pending clr", 32'h0, {31'h0, ti});
    wr(8'h10, 32'h0);
    wr(8'h04, 32'h0);
    end_of_test;
  end
endmodule // serial_bus_control_fields_bench
`default_nettype wire
